// File: bench/ssi_host_model.sv
// Purpose: serial master standing in for the host processor
// Assumes: mode 3 link, clock idle high, 6 ns period only inside frames
// Notes:   data line shows the inverse of its last bit between frames
`timescale 1ns/1ps
module ssi_host_model (
   input  wire logic i_clk,
   input  wire logic i_miso,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_mosi
);
   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end

   // sends the first n bits of w, msb first, and gathers the returned bits
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      #8;
      for (int i = 0; i < n; i++) begin
         o_sclk = 1'b0;
         o_mosi = w[15-i];
         #3;
         r[15-i] = i_miso;
         o_sclk = 1'b1;
         #3;
      end
      repeat (2) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_mosi <= ~o_mosi;
      repeat (9) @(posedge i_clk);
   endtask : xfer
endmodule : ssi_host_model

// File: bench/testbench.sv
// Purpose: self-checking bench for the status, sleep and identification bank
// Assumes: shortened test and sleep counts set as parameters below
// Notes:   a read answer arrives in the frame after the read request
`timescale 1ns/1ps
module testbench;
   localparam logic [15:0] PROD = 16'hC3A1; // arbitrary value
   localparam logic [15:0] LOT1 = 16'h0A01; // arbitrary value
   localparam logic [15:0] LOT2 = 16'h0B02; // arbitrary value
   localparam logic [15:0] LOT3 = 16'h0C03; // arbitrary value
   logic        i_clk, i_rstn, i_ce, i_sclk, i_cs_n, i_mosi, o_miso, o_miso_oe;
   logic        i_tick, i_al1, i_al2, i_ovr, i_stf, i_ckf, i_fd, i_ff;
   logic        o_asleep, o_st_run, o_mt_run;
   logic [15:0] o_misc, v;
   int          mismatches, checked, n;

   initial i_clk = 1'b0;
   always #25 i_clk = ~i_clk;

   ssi_top #(.SELFTEST_CYC(20), .MEMTEST_CYC(12), .HALF_SEC_CYC(10), .PRODUCT_CODE(PROD),
      .LOT_FIRST(LOT1), .LOT_SECOND(LOT2), .LOT_THIRD(LOT3),
      .SERIAL_VALUE(14'h270F)) u_ssi_top (
      .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
      .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe(o_miso_oe), .i_sample_tick(i_tick),
      .i_alarm1(i_al1), .i_alarm2(i_al2), .i_over_range(i_ovr),
      .i_selftest_fail(i_stf), .i_checksum_fail(i_ckf), .i_flash_done(i_fd),
      .i_flash_fail(i_ff), .o_asleep(o_asleep), .o_selftest_run(o_st_run),
      .o_memtest_run(o_mt_run), .o_misc_control(o_misc));

   ssi_host_model u_ssi_host_model (.i_clk(i_clk), .i_miso(o_miso), .o_sclk(i_sclk),
      .o_cs_n(i_cs_n), .o_mosi(i_mosi));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      u_ssi_host_model.xfer({1'b1, a, d}, 16, r);
      #1;
   endtask : wr

   task automatic rd(input logic [6:0] a);
      logic [15:0] r;
      u_ssi_host_model.xfer({1'b0, a, 8'h00}, 16, r);
      u_ssi_host_model.xfer(16'h0000, 16, v);
      #1;
   endtask : rd

   task automatic pulse(input int sel);
      @(posedge i_clk);
      if (sel == 0) i_tick <= 1'b1; else i_fd <= 1'b1;
      @(posedge i_clk);
      i_tick <= 1'b0;
      i_fd   <= 1'b0;
      #1;
   endtask : pulse

   task automatic wait_clear(input int sel);
      logic s;
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
         s = (sel == 0) ? o_st_run : (sel == 1) ? o_mt_run : o_asleep;
      end while (s !== 1'b0 && n < 100);
   endtask : wait_clear

   task automatic do_reset();
      @(posedge i_clk);
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
   endtask : do_reset

   task automatic t_ident();
      rd(ssi_pkg::ADDR_DIAG);   check(v, 16'h0000);
      check(o_misc, 16'h0006);
      check({15'h0000, o_miso_oe}, 16'h0000);
      fork
         rd(ssi_pkg::ADDR_PROD);
         begin
            @(negedge i_cs_n);
            #1;
            check({15'h0000, o_miso_oe}, 16'h0001);
         end
      join
      check(v, PROD);
      wr(ssi_pkg::ADDR_MISC_LO, 8'hFF);
      rd(ssi_pkg::ADDR_MISC_HI); check(v, 16'h0087);
      wr(ssi_pkg::ADDR_MISC_LO, 8'h06);
      check(o_misc, 16'h0006);
      wr(ssi_pkg::ADDR_PROD, 8'h00);
      rd(ssi_pkg::ADDR_PROD);   check(v, PROD);
      rd(ssi_pkg::ADDR_LOT1);   check(v, LOT1);
      rd(ssi_pkg::ADDR_LOT2);   check(v, LOT2);
      rd(ssi_pkg::ADDR_LOT3);   check(v, LOT3);
      rd(ssi_pkg::ADDR_SERIAL); check(v, 16'h270F);
      rd(7'h10);                check(v, 16'h0000);
   endtask : t_ident

   task automatic t_tests();
      i_stf <= 1'b1;
      i_ckf <= 1'b1;
      wr(ssi_pkg::ADDR_MISC_HI, 8'h04);
      check({15'h0000, o_st_run}, 16'h0001);
      @(posedge i_clk);
      i_ce <= 1'b0;
      repeat (40) @(posedge i_clk);
      i_ce <= 1'b1;
      #1;
      check({15'h0000, o_st_run}, 16'h0001);
      wait_clear(0);
      check({15'h0000, n <= 20}, 16'h0001);
      check(o_misc, 16'h0006);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0020);
      wr(ssi_pkg::ADDR_MISC_HI, 8'h08);
      check({15'h0000, o_mt_run}, 16'h0001);
      wait_clear(1);
      check({15'h0000, n <= 12}, 16'h0001);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0040);
      i_stf <= 1'b0;
      i_ckf <= 1'b0;
   endtask : t_tests

   task automatic t_flags();
      i_al2 <= 1'b1;
      pulse(0);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0200);
      i_al1 <= 1'b1;
      i_ovr <= 1'b1;
      pulse(0);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0310);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0000);
      pulse(0);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0310);
      i_al1 <= 1'b0;
      i_al2 <= 1'b0;
      i_ovr <= 1'b0;
      pulse(0);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0000);
      i_ff <= 1'b1;
      pulse(1);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0004);
      pulse(1);
      i_ff <= 1'b0;
      pulse(1);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0000);
      u_ssi_host_model.xfer(16'h0000, 12, v);
      rd(ssi_pkg::ADDR_DIAG); check(v, 16'h0008);
   endtask : t_flags

   task automatic t_sleep();
      wr(ssi_pkg::ADDR_SLEEP, 8'hFF);
      check({15'h0000, o_asleep}, 16'h0001);
      repeat (60) @(posedge i_clk);
      #1;
      check({15'h0000, o_asleep}, 16'h0001);
      rd(7'h00); check({15'h0000, o_asleep}, 16'h0000);
      wr(ssi_pkg::ADDR_SLEEP, 8'h03);
      check({15'h0000, o_asleep}, 16'h0001);
      wait_clear(2);
      check({15'h0000, n >= 18 && n <= 28}, 16'h0001);
      wr(7'h25, 8'h05);
      check({15'h0000, o_asleep}, 16'h0000);
      wr(ssi_pkg::ADDR_SLEEP, 8'hFF);
      do_reset();
      check({15'h0000, o_asleep}, 16'h0000);
   endtask : t_sleep

   task automatic end_sim();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim

   initial begin
      {i_tick, i_al1, i_al2, i_ovr, i_stf, i_ckf, i_fd, i_ff} = 8'h00;
      i_ce       = 1'b1;
      mismatches = 0;
      checked    = 0;
      i_rstn     = 1'b0;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      t_ident();
      t_tests();
      t_flags();
      t_sleep();
      end_sim();
   end

   initial begin
      #1000000;
      mismatches++;
      end_sim();
   end
endmodule : testbench

// File: rtl/ssi_pkg.sv
// Purpose: constants for the status, sleep and identification register bank
// Assumes: 20 MHz system clock, 16-bit serial frames of rw, 7-bit address and data byte
// Notes:   addresses are byte addresses; an even address is a low byte
package ssi_pkg;
   localparam logic [6:0]  ADDR_MISC_LO   = 7'h1C;
   localparam logic [6:0]  ADDR_MISC_HI   = 7'h1D;
   localparam logic [6:0]  ADDR_SLEEP     = 7'h24;
   localparam logic [6:0]  ADDR_DIAG      = 7'h26;
   localparam logic [6:0]  ADDR_LOT1      = 7'h32;
   localparam logic [6:0]  ADDR_LOT2      = 7'h34;
   localparam logic [6:0]  ADDR_LOT3      = 7'h36;
   localparam logic [6:0]  ADDR_PROD      = 7'h38;
   localparam logic [6:0]  ADDR_SERIAL    = 7'h3A;
   localparam int          BIT_MEMTEST    = 11;
   localparam int          BIT_SELFTEST   = 10;
   localparam logic [15:0] MISC_RESET     = 16'h0006;
   localparam logic [7:0]  MISC_LO_MASK   = 8'h87;
   localparam logic [7:0]  MISC_HI_MASK   = 8'h0C;
   localparam logic [7:0]  SLEEP_FOREVER  = 8'hFF;
   localparam logic [15:0] DIAG_RESET     = 16'h0000;
   localparam logic [15:0] DIAG_MASK      = 16'h037C;
   localparam int          FLAG_ALARM2    = 9;
   localparam int          FLAG_ALARM1    = 8;
   localparam int          FLAG_CHECKSUM  = 6;
   localparam int          FLAG_SELFTEST  = 5;
   localparam int          FLAG_OVERRANGE = 4;
   localparam int          FLAG_SPI       = 3;
   localparam int          FLAG_FLASH     = 2;
   localparam int          FRAME_BITS     = 16;
   localparam logic [15:0] SERIAL_MASK    = 16'h3FFF;
   localparam int          CLK_KHZ        = 20000;
   localparam int          SELFTEST_MS    = 245;
   localparam int          MEMTEST_MS     = 21;
   localparam int          HALF_SEC_MS    = 500;
   localparam int          SELFTEST_CYC   = SELFTEST_MS * CLK_KHZ;
   localparam int          MEMTEST_CYC    = MEMTEST_MS * CLK_KHZ;
   localparam int          HALF_SEC_CYC   = HALF_SEC_MS * CLK_KHZ;
   localparam int          SYNC_STAGES    = 3;
endpackage : ssi_pkg

// File: rtl/ssi_top.sv
// Purpose: status, sleep, self test and identification registers behind a serial link
// Assumes: host leaves chip select high for at least 8 i_clk periods between frames
// Notes:   a read frame loads its answer, shifted out during the following frame
`timescale 1ns/1ps
module ssi_top #(
   parameter int          SELFTEST_CYC = ssi_pkg::SELFTEST_CYC,
   parameter int          MEMTEST_CYC  = ssi_pkg::MEMTEST_CYC,
   parameter int          HALF_SEC_CYC = ssi_pkg::HALF_SEC_CYC,
   parameter logic [15:0] PRODUCT_CODE = 16'h5A5A,  // arbitrary value
   parameter logic [15:0] LOT_FIRST    = 16'h1111,  // arbitrary value
   parameter logic [15:0] LOT_SECOND   = 16'h2222,  // arbitrary value
   parameter logic [15:0] LOT_THIRD    = 16'h3333,  // arbitrary value
   parameter logic [13:0] SERIAL_VALUE = 14'h0001   // arbitrary value
) (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic        i_mosi,
   output logic             o_miso,
   output logic             o_miso_oe,
   input  wire logic        i_sample_tick,
   input  wire logic        i_alarm1,
   input  wire logic        i_alarm2,
   input  wire logic        i_over_range,
   input  wire logic        i_selftest_fail,
   input  wire logic        i_checksum_fail,
   input  wire logic        i_flash_done,
   input  wire logic        i_flash_fail,
   output logic             o_asleep,
   output logic             o_selftest_run,
   output logic             o_memtest_run,
   output logic [15:0]      o_misc_control
);
   localparam int HW = $clog2(HALF_SEC_CYC + 1);
   localparam int SW = $clog2(SELFTEST_CYC + 1);
   localparam int MW = $clog2(MEMTEST_CYC + 1);
   localparam int NS = ssi_pkg::SYNC_STAGES;

   // ---------------- link side, on the serial clock ----------------
   typedef struct packed {
      logic [14:0] shift;
      logic [15:0] word;
      logic        tgl;
      logic        partial;
   } ssi_link_s;

   ssi_link_s  lnk;
   ssi_link_s  next_lnk;
   logic [3:0] bit_cnt;
   logic       cnt_clr;

   assign cnt_clr = i_cs_n | ~i_rstn;

   always_ff @(posedge i_sclk or posedge cnt_clr) begin
      if (cnt_clr) begin
         bit_cnt <= 4'h0;
      end else begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   always_comb begin
      next_lnk       = lnk;
      next_lnk.shift = {lnk.shift[13:0], i_mosi};
      next_lnk.partial = (bit_cnt != 4'hF);
      if (bit_cnt == 4'hF) begin
         next_lnk.word = {lnk.shift, i_mosi};
         next_lnk.tgl  = ~lnk.tgl;
      end
   end

   always_ff @(posedge i_sclk or negedge i_rstn) begin
      if (!i_rstn) begin
         lnk <= '0;
      end else begin
         lnk <= next_lnk;
      end
   end

   // ---------------- system side ----------------
   typedef struct packed {
      logic [NS-1:0] cs_sync;
      logic          cs_lvl;
      logic [NS-1:0] rx_sync;
      logic          rx_lvl;
      logic [NS-1:0] part_sync;
      logic [15:0]   misc;
      logic [7:0]    sleep;
      logic [15:0]   diag;
      logic [15:0]   tx;
      logic          asleep;
      logic [HW-1:0] half_cnt;
      logic [7:0]    halves;
      logic [SW-1:0] st_cnt;
      logic [MW-1:0] mt_cnt;
   } ssi_state_s;

   ssi_state_s st;
   ssi_state_s next_st;

   function automatic logic [15:0] reg_read(input logic [6:0] addr, input ssi_state_s s);
      logic [15:0] v;
      v = 16'h0000;
      case ({addr[6:1], 1'b0})
         ssi_pkg::ADDR_MISC_LO: v = s.misc;
         ssi_pkg::ADDR_SLEEP:   v = {8'h00, s.sleep};
         ssi_pkg::ADDR_DIAG:    v = s.diag & ssi_pkg::DIAG_MASK;
         ssi_pkg::ADDR_LOT1:    v = LOT_FIRST;
         ssi_pkg::ADDR_LOT2:    v = LOT_SECOND;
         ssi_pkg::ADDR_LOT3:    v = LOT_THIRD;
         ssi_pkg::ADDR_PROD:    v = PRODUCT_CODE;
         ssi_pkg::ADDR_SERIAL:  v = {2'b00, SERIAL_VALUE} & ssi_pkg::SERIAL_MASK;
         default:               v = 16'h0000;
      endcase
      return v;
   endfunction : reg_read

   logic        cs_fall;
   logic        cs_rise;
   logic        rx_evt;
   logic [15:0] rx_word;
   logic        wr;
   logic [6:0]  rx_addr;
   logic [7:0]  rx_data;
   logic        st_done;
   logic        mt_done;
   logic        diag_rd;
   logic [15:0] flag_set;
   logic [15:0] flag_clr;

   assign cs_fall = st.cs_lvl & (st.cs_sync[NS-1] == st.cs_sync[NS-2]) & ~st.cs_sync[NS-1];
   assign cs_rise = ~st.cs_lvl & (st.cs_sync[NS-1] == st.cs_sync[NS-2]) & st.cs_sync[NS-1];
   assign rx_evt  = (st.rx_sync[NS-1] == st.rx_sync[NS-2]) & (st.rx_sync[NS-1] != st.rx_lvl);
   assign rx_word = lnk.word;
   assign wr      = rx_word[15];
   assign rx_addr = rx_word[14:8];
   assign rx_data = rx_word[7:0];
   assign st_done = st.misc[ssi_pkg::BIT_SELFTEST] && (st.st_cnt == SW'(SELFTEST_CYC - 1));
   assign mt_done = st.misc[ssi_pkg::BIT_MEMTEST] && (st.mt_cnt == MW'(MEMTEST_CYC - 1));
   assign diag_rd = rx_evt && !wr && ({rx_addr[6:1], 1'b0} == ssi_pkg::ADDR_DIAG);

   always_comb begin
      flag_set = 16'h0000;
      flag_clr = 16'h0000;
      if (i_sample_tick && !st.asleep) begin
         flag_set[ssi_pkg::FLAG_ALARM2]    = i_alarm2;
         flag_set[ssi_pkg::FLAG_ALARM1]    = i_alarm1;
         flag_set[ssi_pkg::FLAG_OVERRANGE] = i_over_range;
      end
      if (cs_rise && st.part_sync[NS-1]) begin
         flag_set[ssi_pkg::FLAG_SPI] = 1'b1;
      end
      if (st_done) begin
         flag_set[ssi_pkg::FLAG_SELFTEST] = i_selftest_fail;
         flag_clr[ssi_pkg::FLAG_SELFTEST] = ~i_selftest_fail;
      end
      if (mt_done) begin
         flag_set[ssi_pkg::FLAG_CHECKSUM] = i_checksum_fail;
         flag_clr[ssi_pkg::FLAG_CHECKSUM] = ~i_checksum_fail;
      end
      if (i_flash_done) begin
         flag_set[ssi_pkg::FLAG_FLASH] = i_flash_fail;
         flag_clr[ssi_pkg::FLAG_FLASH] = ~i_flash_fail;
      end
      if (diag_rd) begin
         flag_clr = 16'hFFFF;
      end
   end

   always_comb begin
      next_st           = st;
      next_st.cs_sync   = {st.cs_sync[NS-2:0], i_cs_n};
      next_st.rx_sync   = {st.rx_sync[NS-2:0], lnk.tgl};
      next_st.part_sync = {st.part_sync[NS-2:0], lnk.partial};
      if (st.cs_sync[NS-1] == st.cs_sync[NS-2]) begin
         next_st.cs_lvl = st.cs_sync[NS-1];
      end
      if (rx_evt) begin
         next_st.rx_lvl = st.rx_sync[NS-1];
      end
      // set wins over clear
      next_st.diag = ((st.diag & ~flag_clr) | flag_set) & ssi_pkg::DIAG_MASK;
      // test timers
      if (st.misc[ssi_pkg::BIT_SELFTEST]) begin
         next_st.st_cnt = st.st_cnt + SW'(1);
      end
      if (st_done) begin
         next_st.misc[ssi_pkg::BIT_SELFTEST] = 1'b0;
         next_st.st_cnt = '0;
      end
      if (st.misc[ssi_pkg::BIT_MEMTEST]) begin
         next_st.mt_cnt = st.mt_cnt + MW'(1);
      end
      if (mt_done) begin
         next_st.misc[ssi_pkg::BIT_MEMTEST] = 1'b0;
         next_st.mt_cnt = '0;
      end
      // timed sleep
      if (st.asleep && (st.sleep != ssi_pkg::SLEEP_FOREVER)) begin
         if (st.halves == 8'h00) begin
            next_st.asleep = 1'b0;
         end else if (st.half_cnt == HW'(HALF_SEC_CYC - 1)) begin
            next_st.half_cnt = '0;
            next_st.halves   = st.halves - 8'h01;
         end else begin
            next_st.half_cnt = st.half_cnt + HW'(1);
         end
      end
      if (cs_fall) begin
         next_st.asleep = 1'b0;
      end
      // decoded frame
      if (rx_evt) begin
         if (wr) begin
            case (rx_addr)
               ssi_pkg::ADDR_MISC_LO: begin
                  next_st.misc[7:0] = rx_data & ssi_pkg::MISC_LO_MASK;
               end
               ssi_pkg::ADDR_MISC_HI: begin
                  // request bits only set here; hardware clears them
                  next_st.misc[15:8] = next_st.misc[15:8]
                                       | (rx_data & ssi_pkg::MISC_HI_MASK);
               end
               ssi_pkg::ADDR_SLEEP: begin
                  next_st.sleep    = rx_data;
                  next_st.asleep   = 1'b1;
                  next_st.halves   = rx_data;
                  next_st.half_cnt = '0;
               end
               default: begin
               end
            endcase
         end else begin
            next_st.tx = reg_read(rx_addr, st);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st        <= '0;
         st.cs_sync   <= {NS{1'b1}};
         st.cs_lvl    <= 1'b1;
         st.misc      <= ssi_pkg::MISC_RESET;
         st.diag      <= ssi_pkg::DIAG_RESET;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_miso         = st.tx[~bit_cnt];
   assign o_miso_oe      = ~i_cs_n;
   assign o_asleep       = st.asleep;
   assign o_selftest_run = st.misc[ssi_pkg::BIT_SELFTEST];
   assign o_memtest_run  = st.misc[ssi_pkg::BIT_MEMTEST];
   assign o_misc_control = st.misc;

   // ---------------- checks ----------------
   AST_ST_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st_done) |=> !st.misc[ssi_pkg::BIT_SELFTEST])
      else $error("self-test request not cleared at end of routine");

   AST_ST_RESULT: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st_done && i_selftest_fail) |=> st.diag[ssi_pkg::FLAG_SELFTEST])
      else $error("self-test failure not flagged");

   AST_SLEEP_FF: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && rx_evt && wr && rx_addr == ssi_pkg::ADDR_SLEEP && rx_data == 8'hFF)
      |=> (st.asleep && st.sleep == ssi_pkg::SLEEP_FOREVER))
      else $error("indefinite sleep not entered");

   AST_WAKE_CS: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && cs_fall && !rx_evt) |=> !st.asleep)
      else $error("chip select fall did not wake");

   AST_TIMED_WAKE: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && st.asleep && st.sleep != 8'hFF && st.halves == 8'h00 && !rx_evt)
      |=> !st.asleep)
      else $error("timed sleep did not end");

   AST_DIAG_RESET: assert property (@(posedge i_clk)
      $rose(i_rstn) |-> (st.diag == 16'h0000))
      else $error("flags not zero after reset");

   AST_READ_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && diag_rd && flag_set == 16'h0000)
      |=> (st.diag == 16'h0000 && st.tx == ($past(st.diag) & 16'h037C)))
      else $error("flag read did not return and clear");

   AST_ALARM_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && i_sample_tick && !st.asleep && i_alarm1 && i_alarm2)
      |=> (st.diag[9:8] == 2'b11))
      else $error("alarm flags not set at sample end");

   AST_SPI_ERR: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && cs_rise && st.part_sync[NS-1]) |=> st.diag[ssi_pkg::FLAG_SPI])
      else $error("partial frame not flagged");

   AST_PROD: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (i_ce && rx_evt && !wr && rx_addr == ssi_pkg::ADDR_PROD) |=> (st.tx == PRODUCT_CODE))
      else $error("product code read wrong");

   AST_RSVD: assert property (@(posedge i_clk) disable iff (!i_rstn)
      (st.diag[15:10] == 6'h00) && (st.diag[7] == 1'b0) && (st.diag[1:0] == 2'b00))
      else $error("unused flag bit set");

endmodule : ssi_top
